/* logic/ssfs_pkg.sv */
// Constants, register map and shared types of the speed flag and stop sequence block
package ssfs_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Speed thresholds in r/min
   localparam logic [14:0] THR_MIN = 15'h000a;
   localparam logic [14:0] THR_MAX = 15'h4e20;
   localparam logic [14:0] THR_RST = 15'h0032;
   localparam int HYST_RPM = 10;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ZERO_THR = 8'h04;
   localparam logic [7:0] OFF_ARR_THR = 8'h08;
   localparam logic [7:0] OFF_DET_TIME = 8'h0c;
   localparam logic [7:0] OFF_STOP_TQ = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_INT_STAT = 8'h18;
   localparam logic [7:0] OFF_INT_MASK = 8'h1c;

   // Control register fields
   localparam int CTRL_TRIP_BIT = 0;
   localparam int CTRL_FCLR_BIT = 1;
   localparam int CTRL_OT_LSB = 4;
   localparam int CTRL_PL_LSB = 8;

   // Reset values
   localparam logic CTRL_TRIP_RST = 1'b1;
   localparam logic [15:0] DET_TIME_RST = 16'h0020;
   localparam logic [9:0] STOP_TQ_RST = 10'h064;

   // Interrupt bit positions
   localparam int INT_ZSP = 0;
   localparam int INT_MATCH = 1;
   localparam int INT_REACH = 2;
   localparam int INT_FAULT = 3;
   localparam int INT_OT = 4;
   localparam int INT_PL = 5;
   localparam int INT_W = 6;

   // Over-travel stop codes
   typedef enum logic [1:0] {
      OT_DB = 2'b00,
      OT_ZERO_TQ = 2'b01,
      OT_ESTOP = 2'b10
   } ssfs_ot_code_t;

   // Stop sequence phases
   typedef enum logic [1:0] {
      PH_RUN = 2'b00,
      PH_DECEL = 2'b01,
      PH_STALL = 2'b10
   } ssfs_phase_t;

   // Actions handed to the power stage and position loop
   typedef struct packed {
      logic dynBrake;
      logic freeRun;
      logic eStop;
      logic zeroTqFwd;
      logic zeroTqRev;
      logic cntHold;
      logic cntClear;
   } ssfs_stop_t;

   // State of one hysteresis comparator
   typedef struct packed {
      logic flag;
   } ssfs_cmp_st_t;

   // State of the power-loss timer
   typedef struct packed {
      logic [15:0] count;
      logic expired;
   } ssfs_tmr_st_t;

endpackage : ssfs_pkg

/* logic/ssfs_speed_cmp.sv */
// Threshold comparator with hysteresis on a speed magnitude
`timescale 1ns/1ps
module ssfs_speed_cmp
   import ssfs_pkg::*;
#(
   parameter int WIDTH = 17,
   parameter bit BELOW = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Compare inputs
   input wire logic [WIDTH-1:0] magnitude,
   input wire logic [WIDTH-1:0] threshold,
   // Result
   output logic flag
);

   localparam logic [WIDTH-1:0] HYST = WIDTH'(HYST_RPM);

   ssfs_cmp_st_t st_r;
   ssfs_cmp_st_t st_nxt;
   logic [WIDTH:0] upper;
   logic [WIDTH-1:0] lower;

   always_comb begin
      st_nxt = st_r;
      upper = {1'b0, threshold} + {1'b0, HYST};
      lower = (threshold > HYST) ? (threshold - HYST) : '0;
      if (BELOW) begin
         if (!st_r.flag && (magnitude < threshold)) begin
            st_nxt.flag = 1'b1;
         end else if (st_r.flag && ({1'b0, magnitude} >= upper)) begin // [R4] [R13]
            st_nxt.flag = 1'b0;
         end
      end else begin
         if (!st_r.flag && (magnitude > threshold)) begin
            st_nxt.flag = 1'b1;
         end else if (st_r.flag && (magnitude <= lower)) begin // [R7] [R13]
            st_nxt.flag = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;

endmodule : ssfs_speed_cmp

/* logic/ssfs_loss_timer.sv */
// Counts millisecond ticks while main power is off
`timescale 1ns/1ps
module ssfs_loss_timer
   import ssfs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Timing
   input wire logic tick,
   input wire logic powerOff,
   input wire logic [15:0] detectTime,
   // Result
   output logic expired
);

   ssfs_tmr_st_t st_r;
   ssfs_tmr_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!powerOff) begin
         st_nxt.count = '0;
         st_nxt.expired = 1'b0;
      end else begin
         if (tick && (st_r.count != 16'hffff)) begin
            st_nxt.count = st_r.count + 16'h0001;
         end
         st_nxt.expired = (st_r.count >= detectTime);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign expired = st_r.expired;

endmodule : ssfs_loss_timer

/* logic/ssfs_top.sv */
// Speed flags, over-travel and power-loss stop sequence with APB registers
//
// Overview of operation
// [R1] Zero-speed flag when speed magnitude below threshold
// [R2] Speed-match flag when command error below threshold
// [R3] Zero-speed compare uses magnitude, either direction
// [R4] Zero-speed compare has 10 r/min hysteresis
// [R5] Speed-reached flag when speed exceeds arrival threshold
// [R6] Arrival compare uses speed magnitude only
// [R7] Speed-reached compare has 10 r/min hysteresis
// [R8] Trip select raises undervoltage fault after detect time
// [R9] Over-travel code picks brake, zero torque, emergency stop
// [R10] After stall zero torque; counter hold or clear
// [R11] Emergency stop torque limited by stop torque setting
// [R12] Power-loss code 0..9 picks decel, stall, counter
// [R13] Flags release only past full hysteresis band
`timescale 1ns/1ps
module ssfs_top
   import ssfs_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Motor and supply inputs
   input wire logic signed [15:0] motorSpeed,
   input wire logic signed [15:0] speedCmd,
   input wire logic fwdLimitInput,
   input wire logic reverseLimitInput,
   input wire logic mainPowerOn,
   // Speed flags
   output logic zeroSpeedFlag,
   output logic altZeroSpeedPin,
   output logic speedMatchFlag,
   output logic speedReachedFlag,
   // Stop sequence
   output logic mainUndervoltageFault,
   output ssfs_stop_t stopAction,
   output logic torqueLimitEn,
   output logic [9:0] torqueLimit,
   // Interrupt
   output logic irq
);

   typedef struct packed {
      logic tripSel;
      logic [1:0] otCode;
      logic [3:0] plCode;
      logic [14:0] zeroThr;
      logic [14:0] arrThr;
      logic [15:0] detTime;
      logic [9:0] stopTq;
      logic [INT_W-1:0] intStat;
      logic [INT_W-1:0] intMask;
      logic fault;
      ssfs_phase_t phase;
      logic [14:0] tickCnt;
      logic tick;
      logic [2:0] flags;
      logic otPrev;
      logic plPrev;
      ssfs_stop_t stop;
      logic tqLimitEn;
      logic [9:0] tqLimit;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ssfs_top_st_t;

   ssfs_top_st_t st_r;
   ssfs_top_st_t st_nxt;

   // Speed magnitudes and comparator array
   logic [16:0] speedMag;
   logic [16:0] errMag;
   logic signed [16:0] speedErr;
   logic [16:0] cmpMag [3];
   logic [16:0] cmpThr [3];
   logic [2:0] cmpFlag;
   logic lossExpired;

   assign speedErr = 17'(speedCmd) - 17'(motorSpeed);
   assign speedMag = motorSpeed[15] ? 17'(-17'(motorSpeed)) : 17'(motorSpeed); // [R3] [R6]
   assign errMag = speedErr[16] ? 17'(-speedErr) : 17'(speedErr);
   assign cmpMag[0] = speedMag; // [R1]
   assign cmpThr[0] = {2'b00, st_r.zeroThr};
   assign cmpMag[1] = errMag; // [R2]
   assign cmpThr[1] = {2'b00, st_r.zeroThr};
   assign cmpMag[2] = speedMag; // [R5]
   assign cmpThr[2] = {2'b00, st_r.arrThr};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cmp
         ssfs_speed_cmp #(
            .WIDTH(17),
            .BELOW(gi != 2)
         ) u_cmp (
            .core_clk(core_clk),
            .srst(srst),
            .magnitude(cmpMag[gi]),
            .threshold(cmpThr[gi]),
            .flag(cmpFlag[gi])
         );
      end
   endgenerate

   ssfs_loss_timer u_timer (
      .core_clk(core_clk),
      .srst(srst),
      .tick(st_r.tick),
      .powerOff(!mainPowerOn),
      .detectTime(st_r.detTime),
      .expired(lossExpired)
   );

   function automatic logic [14:0] clampThr(input logic [31:0] v);
      if (v < 32'(THR_MIN)) begin
         return THR_MIN;
      end else if (v > 32'(THR_MAX)) begin
         return THR_MAX;
      end
      return v[14:0];
   endfunction : clampThr

   logic apbAccess;
   logic apbDone;
   logic [31:0] rdVal;
   logic rdErr;
   logic otActive;
   logic plActive;
   logic stalled;
   logic [INT_W-1:0] events;
   logic [INT_W-1:0] w1c;

   always_comb begin
      st_nxt = st_r;
      apbAccess = psel && penable;
      apbDone = apbAccess && st_r.pready;
      otActive = fwdLimitInput || reverseLimitInput;
      plActive = !mainPowerOn;
      stalled = cmpFlag[0];
      w1c = '0;
      rdErr = 1'b0;
      rdVal = '0;

      // Millisecond tick divider
      st_nxt.tick = 1'b0;
      if (st_r.tickCnt >= 15'(TICK_CNT - 1)) begin
         st_nxt.tickCnt = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.tickCnt = st_r.tickCnt + 15'h0001;
      end

      // Read mux
      case (paddr)
         OFF_CTRL: begin
            rdVal[CTRL_TRIP_BIT] = st_r.tripSel;
            rdVal[CTRL_OT_LSB +: 2] = st_r.otCode;
            rdVal[CTRL_PL_LSB +: 4] = st_r.plCode;
         end
         OFF_ZERO_THR: rdVal[14:0] = st_r.zeroThr;
         OFF_ARR_THR: rdVal[14:0] = st_r.arrThr;
         OFF_DET_TIME: rdVal[15:0] = st_r.detTime;
         OFF_STOP_TQ: rdVal[9:0] = st_r.stopTq;
         OFF_STATUS: rdVal[9:0] = {st_r.phase, st_r.fault, plActive, otActive, 2'b00, st_r.flags};
         OFF_INT_STAT: rdVal[INT_W-1:0] = st_r.intStat;
         OFF_INT_MASK: rdVal[INT_W-1:0] = st_r.intMask;
         default: rdErr = 1'b1;
      endcase

      // APB answer one cycle into the access phase
      st_nxt.pready = apbAccess && !st_r.pready;
      if (apbAccess && !st_r.pready) begin
         st_nxt.prdata = pwrite ? 32'h00000000 : (rdErr ? 32'h00000000 : rdVal);
         st_nxt.pslverr = rdErr;
      end else begin
         st_nxt.pslverr = 1'b0;
      end

      // Register writes
      if (apbDone && pwrite) begin
         case (paddr)
            OFF_CTRL: begin
               st_nxt.tripSel = pwdata[CTRL_TRIP_BIT];
               st_nxt.otCode = pwdata[CTRL_OT_LSB +: 2];
               st_nxt.plCode = pwdata[CTRL_PL_LSB +: 4];
               if (pwdata[CTRL_FCLR_BIT] && mainPowerOn) begin
                  st_nxt.fault = 1'b0;
               end
            end
            OFF_ZERO_THR: st_nxt.zeroThr = clampThr(pwdata);
            OFF_ARR_THR: st_nxt.arrThr = clampThr(pwdata);
            OFF_DET_TIME: st_nxt.detTime = pwdata[15:0];
            OFF_STOP_TQ: st_nxt.stopTq = pwdata[9:0];
            OFF_INT_STAT: w1c = pwdata[INT_W-1:0];
            OFF_INT_MASK: st_nxt.intMask = pwdata[INT_W-1:0];
            default: ;
         endcase
      end

      // Undervoltage fault
      if (st_r.tripSel && lossExpired) begin // [R8]
         st_nxt.fault = 1'b1;
      end

      // Flags to pins
      st_nxt.flags = cmpFlag;

      // Stop sequence phases
      st_nxt.otPrev = otActive;
      st_nxt.plPrev = plActive;
      case (st_r.phase)
         PH_RUN: begin
            if (otActive || plActive) begin
               st_nxt.phase = PH_DECEL;
            end
         end
         PH_DECEL: begin
            if (!otActive && !plActive) begin
               st_nxt.phase = PH_RUN;
            end else if (stalled) begin
               st_nxt.phase = PH_STALL;
            end
         end
         PH_STALL: begin
            if (!otActive && !plActive) begin
               st_nxt.phase = PH_RUN;
            end
         end
         default: st_nxt.phase = PH_RUN;
      endcase

      // Actions for the coming phase
      st_nxt.stop = '0;
      st_nxt.tqLimitEn = 1'b0;
      st_nxt.tqLimit = '0;
      if (st_nxt.phase != PH_RUN) begin
         if (plActive) begin
            if (st_r.tripSel && st_nxt.fault) begin
               st_nxt.stop.dynBrake = 1'b1;
               st_nxt.stop.cntClear = 1'b1;
            end else if (st_r.plCode >= 4'h8 && st_r.plCode <= 4'h9) begin // [R12]
               st_nxt.stop.eStop = (st_nxt.phase == PH_DECEL);
               st_nxt.stop.dynBrake = (st_nxt.phase == PH_STALL);
               st_nxt.stop.cntClear = 1'b1;
            end else if (st_r.plCode <= 4'h7) begin // [R12]
               if (st_nxt.phase == PH_DECEL) begin
                  st_nxt.stop.freeRun = st_r.plCode[0];
               end else begin
                  st_nxt.stop.freeRun = st_r.plCode[1];
               end
               st_nxt.stop.dynBrake = !st_nxt.stop.freeRun;
               st_nxt.stop.cntHold = st_r.plCode[2];
               st_nxt.stop.cntClear = !st_r.plCode[2];
            end else begin
               st_nxt.stop.dynBrake = 1'b1;
               st_nxt.stop.cntClear = 1'b1;
            end
         end else begin
            if (st_nxt.phase == PH_STALL) begin // [R10]
               st_nxt.stop.zeroTqFwd = fwdLimitInput;
               st_nxt.stop.zeroTqRev = reverseLimitInput;
            end else begin
               case (st_r.otCode) // [R9]
                  OT_ZERO_TQ: begin
                     st_nxt.stop.zeroTqFwd = fwdLimitInput;
                     st_nxt.stop.zeroTqRev = reverseLimitInput;
                  end
                  OT_ESTOP: st_nxt.stop.eStop = 1'b1;
                  default: st_nxt.stop.dynBrake = 1'b1;
               endcase
            end
            if (st_r.otCode == OT_ESTOP) begin // [R10]
               st_nxt.stop.cntClear = (st_r.phase != st_nxt.phase);
            end else begin
               st_nxt.stop.cntHold = 1'b1;
            end
         end
      end
      if (st_nxt.stop.eStop) begin // [R11]
         st_nxt.tqLimitEn = 1'b1;
         st_nxt.tqLimit = st_r.stopTq;
      end

      // Sticky interrupt status, set wins over clear
      events[INT_ZSP] = cmpFlag[0] && !st_r.flags[0];
      events[INT_MATCH] = cmpFlag[1] && !st_r.flags[1];
      events[INT_REACH] = cmpFlag[2] && !st_r.flags[2];
      events[INT_FAULT] = st_nxt.fault && !st_r.fault;
      events[INT_OT] = otActive && !st_r.otPrev;
      events[INT_PL] = plActive && !st_r.plPrev;
      st_nxt.intStat = (st_r.intStat & ~w1c) | events;
      st_nxt.irq = |(st_nxt.intStat & st_nxt.intMask);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.tripSel <= CTRL_TRIP_RST;
         st_r.zeroThr <= THR_RST;
         st_r.arrThr <= THR_RST;
         st_r.detTime <= DET_TIME_RST;
         st_r.stopTq <= STOP_TQ_RST;
         st_r.phase <= PH_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign zeroSpeedFlag = st_r.flags[0];
   assign altZeroSpeedPin = st_r.flags[0];
   assign speedMatchFlag = st_r.flags[1];
   assign speedReachedFlag = st_r.flags[2];
   assign mainUndervoltageFault = st_r.fault;
   assign stopAction = st_r.stop;
   assign torqueLimitEn = st_r.tqLimitEn;
   assign torqueLimit = st_r.tqLimit;
   assign irq = st_r.irq;

endmodule : ssfs_top

/* tb/ssfs_top_properties.sv */
// Concurrent checks of the speed flag and stop sequence block
`timescale 1ns/1ps
module ssfs_top_checker
   import ssfs_pkg::*;
#(
   parameter int TICK_CNT = 10
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Motor and supply
   input wire logic signed [15:0] motorSpeed,
   input wire logic signed [15:0] speedCmd,
   input wire logic mainPowerOn,
   // Outputs watched
   input wire logic zeroSpeedFlag,
   input wire logic speedMatchFlag,
   input wire logic speedReachedFlag,
   input wire logic mainUndervoltageFault,
   input wire ssfs_stop_t stopAction,
   input wire logic torqueLimitEn,
   input wire logic [9:0] torqueLimit
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   int zThr, aThr, det, stq, offCnt, magI, errI;
   logic trip;
   function automatic int clampThr(input logic [31:0] v);
      return v[14:0] < THR_MIN ? int'(THR_MIN) : (v[14:0] > THR_MAX ? int'(THR_MAX) : int'(v[14:0]));
   endfunction : clampThr
   // Shadow of speed magnitudes and of the registers written over the bus
   always_comb begin
      magI = motorSpeed < 0 ? -int'(motorSpeed) : int'(motorSpeed);
      errI = int'(speedCmd) - int'(motorSpeed);
      errI = errI < 0 ? -errI : errI;
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         zThr <= int'(THR_RST);
         aThr <= int'(THR_RST);
         det <= int'(DET_TIME_RST);
         stq <= int'(STOP_TQ_RST);
         trip <= CTRL_TRIP_RST;
         offCnt <= 0;
      end else begin
         offCnt <= mainPowerOn ? 0 : offCnt + 1;
         if (psel && penable && pready && pwrite && !pslverr) begin
            case (paddr)
               OFF_CTRL: trip <= pwdata[CTRL_TRIP_BIT];
               OFF_ZERO_THR: zThr <= clampThr(pwdata);
               OFF_ARR_THR: aThr <= clampThr(pwdata);
               OFF_DET_TIME: det <= int'(pwdata[15:0]);
               OFF_STOP_TQ: stq <= int'(pwdata[9:0]);
               default: ;
            endcase
         end
      end
   end
   sequence s_setup; psel && !penable; endsequence
   sequence s_wait; psel && penable && !pready; endsequence
   property p_ready; s_setup ##1 s_wait |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready not in second access cycle");
   property p_zsp_on; (magI < zThr) [*3] |-> zeroSpeedFlag; endproperty
   a_zsp_on: assert property (p_zsp_on) else $error("zero speed flag not set");
   property p_zsp_off; (magI >= zThr + HYST_RPM) [*3] |-> !zeroSpeedFlag; endproperty
   a_zsp_off: assert property (p_zsp_off) else $error("zero speed flag not released");
   property p_zsp_hold; (magI >= zThr && magI < zThr + HYST_RPM) [*4] |-> $stable(zeroSpeedFlag); endproperty
   a_zsp_hold: assert property (p_zsp_hold) else $error("zero speed flag moved in band");
   property p_match; (errI < zThr) [*3] |-> speedMatchFlag; endproperty
   a_match: assert property (p_match) else $error("speed match flag not set");
   property p_reach_on; (magI > aThr) [*3] |-> speedReachedFlag; endproperty
   a_reach_on: assert property (p_reach_on) else $error("speed reached flag not set");
   property p_reach_off; (magI <= aThr - HYST_RPM) [*3] |-> !speedReachedFlag; endproperty
   a_reach_off: assert property (p_reach_off) else $error("speed reached flag not released");
   property p_no_trip; !trip [*3] |-> !$rose(mainUndervoltageFault); endproperty
   a_no_trip: assert property (p_no_trip) else $error("fault raised with trip off");
   property p_fault_due; trip && $past(trip) && offCnt == det * TICK_CNT + 2 |-> mainUndervoltageFault; endproperty
   a_fault_due: assert property (p_fault_due) else $error("fault late");
   property p_tq; stopAction.eStop |-> torqueLimitEn && torqueLimit == 10'(stq); endproperty
   a_tq: assert property (p_tq) else $error("stop torque not applied");
endmodule : ssfs_top_checker

bind ssfs_top ssfs_top_checker #(.TICK_CNT(TICK_CNT)) u_chk (.core_clk, .srst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .motorSpeed, .speedCmd, .mainPowerOn, .zeroSpeedFlag, .speedMatchFlag,
   .speedReachedFlag, .mainUndervoltageFault, .stopAction, .torqueLimitEn, .torqueLimit);

/* tb/ssfs_motor_model.sv */
// Motor and power stage model facing the stop sequence outputs
`timescale 1ns/1ps
module ssfs_motor_model
   import ssfs_pkg::*;
#(
   parameter int STEP = 20
) (
   // Clock
   input wire logic core_clk,
   // Demand and stop actions
   input wire logic signed [15:0] speedTarget,
   input wire ssfs_stop_t stopAction,
   // Measured speed
   output logic signed [15:0] motorSpeed
);
   int s;
   initial motorSpeed = 16'sh0;
   // Any brake, free-run, emergency stop or zero torque action runs the shaft down; otherwise it follows the demand
   always @(posedge core_clk) begin
      s = int'(motorSpeed);
      if (|stopAction[6:2])
         s = s > STEP ? s - STEP : (s < -STEP ? s + STEP : 0);
      else
         s = int'(speedTarget);
      motorSpeed <= 16'(s);
   end
endmodule : ssfs_motor_model

/* tb/tb_top.sv */
// Self-checking bench for the speed flag and stop sequence block
`timescale 1ns/1ps
module tb_top
   import ssfs_pkg::*;
;
   logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic signed [15:0] speedTarget = 16'sh0, speedCmd = 16'sh0, motorSpeed;
   logic fwdLimitInput = 1'b0, reverseLimitInput = 1'b0, mainPowerOn = 1'b1;
   logic zeroSpeedFlag, altZeroSpeedPin, speedMatchFlag, speedReachedFlag, mainUndervoltageFault, torqueLimitEn, irq;
   logic [9:0] torqueLimit;
   ssfs_stop_t stopAction;
   int bad_count = 0, total_checks = 0, zt, at, m, stq, sp = 0, ce = 0;
   logic z = 1'b0, v = 1'b0, r = 1'b0;
   logic [7:0] rstAddr [6] = '{OFF_CTRL, OFF_ZERO_THR, OFF_ARR_THR, OFF_DET_TIME, OFF_STOP_TQ, OFF_INT_MASK};
   logic [31:0] rstVal [6] = '{32'h1, 32'h32, 32'h32, 32'h20, 32'h64, 32'h0};
   logic [31:0] clampIn [3] = '{32'h5, 32'h7530, 32'h4e20};

   ssfs_top #(.TICK_CNT(10)) dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .motorSpeed, .speedCmd, .fwdLimitInput, .reverseLimitInput, .mainPowerOn, .zeroSpeedFlag,
      .altZeroSpeedPin, .speedMatchFlag, .speedReachedFlag, .mainUndervoltageFault, .stopAction, .torqueLimitEn,
      .torqueLimit, .irq);
   ssfs_motor_model #(.STEP(20)) u_motor (.core_clk, .speedTarget, .stopAction, .motorSpeed);

   always #20 core_clk = ~core_clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bound(input int k, input int limit);
      if (k >= limit) begin
         bad_count++;
         $display("mismatch at %0t: wait ran out", $time);
         report_and_stop();
      end
   endtask : bound

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      bound(k, 20);
      @(posedge core_clk);
   endtask : apb

   task automatic awaitHigh(input logic sel, input int limit);
      int k = 0;
      while ((sel ? mainUndervoltageFault : zeroSpeedFlag) !== 1'b1 && k < limit) begin
         @(posedge core_clk);
         k++;
      end
      bound(k, limit);
   endtask : awaitHigh

   function automatic logic hyst(input logic cur, input int mag, input int thr, input logic below);
      if (below) return mag < thr ? 1'b1 : (mag >= thr + HYST_RPM ? 1'b0 : cur);
      return mag > thr ? 1'b1 : (mag <= thr - HYST_RPM ? 1'b0 : cur);
   endfunction : hyst

   function automatic int absI(input int x);
      return x < 0 ? -x : x;
   endfunction : absI

   function automatic logic [31:0] clampExp(input logic [31:0] d);
      return d[14:0] < THR_MIN ? 32'(THR_MIN) : (d[14:0] > THR_MAX ? 32'(THR_MAX) : 32'(d[14:0]));
   endfunction : clampExp

   function automatic logic [6:0] plExp(input logic [3:0] c, input logic stall);
      logic f;
      f = stall ? c[1] : c[0];
      if (c > 4'h7) return {stall, 1'b0, !stall, 4'h1};
      return {!f, f, 3'b000, c[2], !c[2]};
   endfunction : plExp

   initial begin
      void'($urandom(32'h156f));
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      // Reset values, unmapped address, threshold clamping
      foreach (rstAddr[i]) begin
         apb(1'b0, rstAddr[i], 32'h0, rd, er);
         chk(rd, rstVal[i]);
      end
      apb(1'b0, 8'h40, 32'h0, rd, er);
      chk(er, 1'b1);
      foreach (clampIn[i]) begin
         apb(1'b1, OFF_ZERO_THR, clampIn[i], rd, er);
         apb(1'b0, OFF_ZERO_THR, 32'h0, rd, er);
         chk(rd, clampExp(clampIn[i]));
      end
      // Random speeds around both thresholds, either direction
      for (int i = 0; i < 40; i++) begin
         zt = $urandom_range(10, 400);
         at = $urandom_range(10, 400);
         apb(1'b1, OFF_ZERO_THR, 32'(zt), rd, er);
         apb(1'b1, OFF_ARR_THR, 32'(at), rd, er);
         z = hyst(z, absI(sp), zt, 1'b1);
         v = hyst(v, absI(ce), zt, 1'b1);
         r = hyst(r, absI(sp), at, 1'b0);
         m = (i % 2 == 1 ? zt : at) + int'($urandom_range(0, 24)) - 12;
         sp = $urandom_range(0, 1) ? -m : m;
         ce = int'($urandom_range(0, 2 * zt + 20)) - zt - 10;
         speedTarget <= 16'(sp);
         // Command follows one cycle later, matching the shaft's lag
         @(posedge core_clk);
         speedCmd <= 16'(sp + ce);
         repeat (4) @(posedge core_clk);
         z = hyst(z, absI(sp), zt, 1'b1);
         v = hyst(v, absI(ce), zt, 1'b1);
         r = hyst(r, absI(sp), at, 1'b0);
         chk(zeroSpeedFlag, z);
         chk(altZeroSpeedPin, z);
         chk(speedMatchFlag, v);
         chk(speedReachedFlag, r);
      end
      // Interrupt raised, cleared and masked
      apb(1'b1, OFF_INT_MASK, 32'h1, rd, er);
      speedTarget <= 16'sh3e8;
      repeat (5) @(posedge core_clk);
      apb(1'b1, OFF_INT_STAT, 32'h3f, rd, er);
      chk(irq, 1'b0);
      speedTarget <= 16'sh0;
      repeat (5) @(posedge core_clk);
      chk(irq, 1'b1);
      apb(1'b1, OFF_INT_STAT, 32'h1, rd, er);
      chk(irq, 1'b0);
      // Over-travel codes
      stq = $urandom_range(0, 1023);
      apb(1'b1, OFF_STOP_TQ, 32'(stq), rd, er);
      for (int c = 0; c < 3; c++) begin
         speedTarget <= 16'sh3e8;
         repeat (5) @(posedge core_clk);
         apb(1'b1, OFF_CTRL, 32'(c << CTRL_OT_LSB) | 32'h1, rd, er);
         fwdLimitInput <= (c != 1);
         reverseLimitInput <= (c == 1);
         repeat (3) @(posedge core_clk);
         chk({stopAction.dynBrake, stopAction.zeroTqRev, stopAction.eStop}, 32'h4 >> c);
         if (c == 2) chk({torqueLimitEn, torqueLimit}, {1'b1, 10'(stq)});
         awaitHigh(1'b0, 300);
         repeat (3) @(posedge core_clk);
         chk({stopAction.zeroTqFwd, stopAction.zeroTqRev, stopAction.cntHold}, {c != 1, c == 1, c < 2});
         fwdLimitInput <= 1'b0;
         reverseLimitInput <= 1'b0;
      end
      // Power loss with trip off, then trip on
      speedTarget <= 16'sh3e8;
      repeat (5) @(posedge core_clk);
      m = $urandom_range(0, 9);
      apb(1'b1, OFF_CTRL, 32'(m) << CTRL_PL_LSB, rd, er);
      mainPowerOn <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(stopAction, plExp(4'(m), 1'b0));
      awaitHigh(1'b0, 300);
      repeat (3) @(posedge core_clk);
      chk(stopAction, plExp(4'(m), 1'b1));
      repeat (400) @(posedge core_clk);
      chk(mainUndervoltageFault, 1'b0);
      mainPowerOn <= 1'b1;
      apb(1'b1, OFF_DET_TIME, 32'h3, rd, er);
      apb(1'b1, OFF_CTRL, 32'h301, rd, er);
      mainPowerOn <= 1'b0;
      awaitHigh(1'b1, 80);
      chk(mainUndervoltageFault, 1'b1);
      chk(stopAction, 32'h41);
      repeat (10) @(posedge core_clk);
      mainPowerOn <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h3, rd, er);
      chk(mainUndervoltageFault, 1'b0);
      report_and_stop();
   end
endmodule : tb_top
